// File: logic/xbp_pkg.sv
// Notes on behaviour
// - one request input per dma channel, channels 7-5 and 3-0
// - one dma grant per channel, high only when that channel owns the bus
// - each master slot has its own request input and grant output
// - refresh line driven only while dma is master serving internal refresh
// - refresh line is an input while a 16-bit isa master drives it
// - command strobe tristates the data port after a read cycle
// - end-of-transfer mode one: slave input stops the running dma transfer
// - end-of-transfer mode two: slave input acts as terminal count
// - end-of-transfer mode three: drive line when chain buffer expires
// - interrupt request inputs for lines 15 down to 3, and line 1
// - master mode drives all four byte enables
// - slave mode: upper three byte enables are inputs, lowest always output
// - slave mode drives ready whenever a slave write hits own registers
// - master mode: ready input completes cycle, next burst address follows
// - data port driven only while selected in io read or int ack
// - slave select asserted whenever accessed as a slave
// - address enable shows whether host, eisa or isa master owns the bus
// - channel check error input can be programmed to raise nmi
// - slave mode decodes every bus cycle for register access
// - master mode runs own dma or refresh cycles
// - requesters sit on priority levels, rotating within each level
`default_nettype none
package xbp_pkg;
  localparam int unsigned dma_channels  = 8;  // index 4 is the cascade hole
  localparam int unsigned slot_count    = 6;
  localparam int unsigned irq_lines     = 16;
  localparam logic [7:0]  dma_valid_mask = 8'hEF;
  localparam logic [15:0] irq_valid_mask = 16'hFFFA;
  localparam logic [7:0]  reset_data     = 8'h00;
  // ownership shown on the address enable code
  typedef enum logic [1:0] {
    xbp_own_host = 2'b00,
    xbp_own_eisa = 2'b01,
    xbp_own_isa  = 2'b11
  } xbp_owner_type;
  // end-of-transfer handling
  typedef enum logic [1:0] {
    xbp_eot_stop   = 2'b00,
    xbp_eot_tc     = 2'b01,
    xbp_eot_chain  = 2'b10
  } xbp_eot_type;
  // arbiter state, gray in the order idle-dma-slot-refresh
  typedef enum logic [1:0] {
    xbp_idle    = 2'b00,
    xbp_dma     = 2'b01,
    xbp_slot    = 2'b11,
    xbp_refresh = 2'b10
  } xbp_state_type;
endpackage
`default_nettype wire

// File: logic/xbp_top.sv
`default_nettype none
module xbp_top (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            dma_request,
  output var  logic [7:0]            dma_grant,
  input  wire logic [5:0]            slot_master_request,
  output var  logic [5:0]            slot_master_grant_n,
  input  wire logic                  refresh_request,
  input  wire logic                  isa16_master_active,
  input  wire logic                  refresh_line_in_n,
  output var  logic                  refresh_line_out_n,
  output var  logic                  refresh_line_oe_n,
  input  wire logic                  command_strobe_n,
  input  wire logic                  io_read,
  input  wire logic                  int_ack,
  input  wire logic                  slave_write,
  input  wire logic                  address_hit,
  input  wire xbp_pkg::xbp_eot_type  eot_mode,
  input  wire logic                  chain_expired,
  input  wire logic                  end_of_transfer_line_in,
  output var  logic                  end_of_transfer_line_out,
  output var  logic                  end_of_transfer_line_oe_n,
  output var  logic                  transfer_stop,
  output var  logic                  terminal_count,
  input  wire logic [15:0]           irq_request,
  output var  logic [15:0]           irq_pending,
  input  wire logic [3:0]            bus_byte_enables_in_n,
  input  wire logic [3:0]            master_byte_enables_n,
  output var  logic [3:0]            bus_byte_enables_out_n,
  output var  logic [3:0]            bus_byte_enables_oe_n,
  output var  logic [2:0]            slave_register_select_n,
  input  wire logic                  cycle_ready_line_in_n,
  output var  logic                  cycle_ready_line_out_n,
  output var  logic                  cycle_ready_line_oe_n,
  output var  logic                  burst_next_address,
  input  wire logic [7:0]            read_data,
  output var  logic [7:0]            register_data_port_out,
  output var  logic                  register_data_port_oe_n,
  output var  logic                  slave_select_out_n,
  output var  logic [1:0]            address_enable_out,
  input  wire logic                  channel_check_error_n,
  input  wire logic                  nmi_on_check_enable,
  output var  logic                  nmi_request
);
  import xbp_pkg::*;

  // two-flop synchronisers for dma, slot and irq requests, byte enables and ten control pins
  logic [7:0]  dreq_s1, dreq;
  logic [5:0]  sreq_s1, sreq;
  logic [15:0] irq_s1, irq;
  logic [3:0]  be_s1, be_in;
  logic [9:0]  misc_s1, misc;
  logic        cmd_n, eot_in, rdy_n, chk_n, ref_in_n;
  logic        isa16, io_rd, iack, swr, hit;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dreq_s1 <= '0;
      dreq    <= '0;
      sreq_s1 <= '0;
      sreq    <= '0;
      irq_s1  <= '0;
      irq     <= '0;
      be_s1   <= 4'hF;
      be_in   <= 4'hF;
      misc_s1 <= 10'h2E0; // idle levels, so no false hit after reset
      misc    <= 10'h2E0;
    end else begin
      dreq_s1 <= dma_request & dma_valid_mask;
      dreq    <= dreq_s1;
      sreq_s1 <= slot_master_request;
      sreq    <= sreq_s1;
      irq_s1  <= irq_request & irq_valid_mask;
      irq     <= irq_s1;
      be_s1   <= bus_byte_enables_in_n;
      be_in   <= be_s1;
      misc_s1 <= {command_strobe_n, end_of_transfer_line_in,
                  cycle_ready_line_in_n, channel_check_error_n,
                  refresh_line_in_n, isa16_master_active, io_read,
                  int_ack, slave_write, address_hit};
      misc    <= misc_s1;
    end
  end

  assign {cmd_n, eot_in, rdy_n, chk_n, ref_in_n, isa16, io_rd, iack,
          swr, hit} = misc;

  // arbiter: refresh first, then dma, then slots; rotation inside levels
  xbp_state_type state;
  logic [2:0] dma_last;
  logic [2:0] slot_last;
  logic [2:0] dma_pick;
  logic [2:0] slot_pick;
  logic       dma_any;
  logic       slot_any;
  logic       master_mode;
  logic       req_live;

  // round robin search starting after the last winner
  always_comb begin
    logic [3:0] idx;
    dma_pick = dma_last;
    dma_any  = 1'b0;
    idx      = '0;
    // nearest follower of the last winner is tried last, so it wins
    for (int i = 8; i >= 1; i--) begin
      idx = 4'(dma_last) + 4'(i);
      if (dreq[idx[2:0]]) begin
        dma_pick = idx[2:0];
        dma_any  = 1'b1;
      end
    end
  end

  always_comb begin
    logic [3:0] idx;
    slot_pick = slot_last;
    slot_any  = 1'b0;
    idx       = '0;
    for (int i = 6; i >= 1; i--) begin
      idx = 4'(slot_last) + 4'(i);
      if (idx >= 4'd6) idx = idx - 4'd6;
      if (sreq[idx[2:0]]) begin
        slot_pick = idx[2:0];
        slot_any  = 1'b1;
      end
    end
  end

  // a grant holds while its requester keeps asking, a dma grant only until transfer_stop
  always_comb begin
    case (state)
      xbp_dma:     req_live = dreq[dma_last] && !transfer_stop;
      xbp_slot:    req_live = sreq[slot_last];
      xbp_refresh: req_live = refresh_request;
      default:     req_live = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= xbp_idle;
      dma_last  <= 3'h7;
      slot_last <= 3'h5;
    end else if (state == xbp_idle) begin
      // no own refresh while an adapter holds the refresh line low
      if (refresh_request && !isa16 && ref_in_n)
        state <= xbp_refresh;
      // a slave holding the stop line keeps dma off the bus
      else if (dma_any && !(eot_in && eot_mode == xbp_eot_stop)) begin
        state    <= xbp_dma;
        dma_last <= dma_pick;
      end else if (slot_any) begin
        state     <= xbp_slot;
        slot_last <= slot_pick;
      end
    end else if (!req_live) begin
      state <= xbp_idle; // one idle cycle between owners keeps grants apart
    end
  end

  // grants, one-hot by construction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_grant           <= '0;
      slot_master_grant_n <= 6'h3F;
    end else begin
      dma_grant           <= '0;
      slot_master_grant_n <= 6'h3F;
      if (state == xbp_dma && req_live)
        dma_grant[dma_last] <= 1'b1;
      if (state == xbp_slot && req_live)
        slot_master_grant_n[slot_last] <= 1'b0;
    end
  end

  assign master_mode = (state == xbp_dma) || (state == xbp_refresh);

  // refresh line drive, released for a 16-bit isa master
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refresh_line_out_n <= 1'b1;
      refresh_line_oe_n  <= 1'b1;
    end else begin
      refresh_line_out_n <= !(state == xbp_refresh);
      refresh_line_oe_n  <= !(state == xbp_refresh && !isa16);
    end
  end

  // end-of-transfer handling by mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      transfer_stop             <= 1'b0;
      terminal_count            <= 1'b0;
      end_of_transfer_line_out  <= 1'b0;
      end_of_transfer_line_oe_n <= 1'b1;
    end else begin
      transfer_stop  <= eot_in && state == xbp_dma &&
                        eot_mode == xbp_eot_stop;
      terminal_count <= eot_in && state == xbp_dma &&
                        eot_mode == xbp_eot_tc;
      end_of_transfer_line_out  <= chain_expired &&
                                   eot_mode == xbp_eot_chain;
      end_of_transfer_line_oe_n <= !(eot_mode == xbp_eot_chain);
    end
  end

  // interrupt request levels as seen after synchronising
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) irq_pending <= '0;
    else irq_pending <= irq;
  end

  // byte enables: all four in master mode, lowest always driven
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_byte_enables_out_n  <= 4'hF;
      bus_byte_enables_oe_n   <= 4'hE;
      slave_register_select_n <= 3'h7;
    end else begin
      bus_byte_enables_out_n  <= master_byte_enables_n;
      bus_byte_enables_oe_n   <= master_mode ? 4'h0 : 4'hE;
      slave_register_select_n <= be_in[3:1];
    end
  end

  // slave decode and select
  logic slave_access;
  assign slave_access = hit && !master_mode;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) slave_select_out_n <= 1'b1;
    else slave_select_out_n <= !slave_access;
  end

  // ready: output on slave write, input in master mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cycle_ready_line_out_n <= 1'b1;
      cycle_ready_line_oe_n  <= 1'b1;
      burst_next_address     <= 1'b0;
    end else begin
      cycle_ready_line_out_n <= !(slave_access && swr);
      cycle_ready_line_oe_n  <= !(slave_access && swr);
      burst_next_address     <= master_mode && !rdy_n;
    end
  end

  // data port drives only for reads while selected, dropped on strobe end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      register_data_port_out  <= reset_data;
      register_data_port_oe_n <= 1'b1;
    end else begin
      register_data_port_out <= read_data;
      register_data_port_oe_n <= !(slave_access && (io_rd || iack) &&
                                   !cmd_n);
    end
  end

  // bus ownership code and check error nmi
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      address_enable_out <= xbp_own_host;
      nmi_request        <= 1'b0;
    end else begin
      if (state == xbp_slot)
        address_enable_out <= isa16 ? xbp_own_isa : xbp_own_eisa;
      else
        address_enable_out <= xbp_own_host;
      nmi_request <= !chk_n && nmi_on_check_enable;
    end
  end
endmodule
`default_nettype wire

// File: verif/xbp_monitor.sv
`default_nettype none
module xbp_monitor (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic [7:0]           dma_request,
  input wire logic [7:0]           dma_grant,
  input wire logic [5:0]           slot_master_grant_n,
  input wire logic                 refresh_line_oe_n,
  input wire logic                 refresh_line_out_n,
  input wire logic [3:0]           bus_byte_enables_oe_n,
  input wire logic                 address_hit,
  input wire logic                 slave_write,
  input wire logic                 slave_select_out_n,
  input wire logic                 cycle_ready_line_oe_n,
  input wire xbp_pkg::xbp_eot_type eot_mode,
  input wire logic                 end_of_transfer_line_oe_n,
  input wire logic [15:0]          irq_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  import xbp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // grant steps: rise traced to a request, release after request drops
  sequence grant_rise_s;
    $rose(|dma_grant);
  endsequence
  sequence grant_orphan_s;
    (dma_grant & ~dma_request) != 8'h00;
  endsequence
  chk_one_owner: assert property (
    $onehot0({dma_grant, ~slot_master_grant_n}))
    else $error("more than one bus owner");
  chk_grant_cause: assert property (
    grant_rise_s |-> |($past(dma_request, 4) & dma_grant))
    else $error("grant without request");
  chk_grant_drop: assert property (
    grant_orphan_s |-> ##[1:5] dma_grant == 8'h00)
    else $error("grant held after request fell");
  chk_refresh_drive: assert property (
    !refresh_line_oe_n |-> !refresh_line_out_n && dma_grant == 8'h00)
    else $error("refresh driven outside refresh");
  chk_master_be: assert property (
    grant_rise_s |-> ##1 bus_byte_enables_oe_n == 4'h0)
    else $error("byte enables not driven as master");
  chk_low_be_out: assert property (
    bus_byte_enables_oe_n == 4'h0 || bus_byte_enables_oe_n == 4'hE)
    else $error("byte enable direction wrong");
  chk_select_cause: assert property (
    !slave_select_out_n |-> $past(address_hit, 3))
    else $error("select without address hit");
  chk_ready_cause: assert property (
    !cycle_ready_line_oe_n |-> $past(slave_write && address_hit, 3))
    else $error("ready driven without slave write");
  chk_eot_chain: assert property (
    end_of_transfer_line_oe_n == ($past(eot_mode, 1) != xbp_eot_chain))
    else $error("end of transfer drive wrong");
  chk_irq_mask: assert property (
    (irq_pending & ~irq_valid_mask) == 16'h0000)
    else $error("absent interrupt line pending");
endmodule
`default_nettype wire

// File: verif/xbp_far_end_model.sv
`default_nettype none
module xbp_far_end_model #(
  parameter int unsigned ready_delay = 1
) (
  input  wire logic       clk,
  input  wire logic [7:0] dma_grant,
  input  wire logic [3:0] bus_byte_enables_out_n,
  input  wire logic [3:0] bus_byte_enables_oe_n,
  input  wire logic [2:0] far_select_n,
  output var  logic [3:0] bus_byte_enables_in_n,
  output var  logic       cycle_ready_line_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned wait_cnt = 0;
  // wire level: released bits take the far master's select, bit 0 idle high
  assign bus_byte_enables_in_n = (bus_byte_enables_oe_n & {far_select_n, 1'b1})
    | (~bus_byte_enables_oe_n & bus_byte_enables_out_n);
  // addressed slave completes every ready_delay+1 cycles, pull-up otherwise
  always @(posedge clk) begin
    if (dma_grant == 8'h00 || wait_cnt == ready_delay) wait_cnt <= 0;
    else wait_cnt <= wait_cnt + 1;
  end
  assign cycle_ready_line_in_n = !(dma_grant != 8'h00
    && wait_cnt == ready_delay);
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import xbp_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, refresh_request = 1'b0;
  logic        isa16_master_active = 1'b0, command_strobe_n = 1'b1;
  logic        io_read = 1'b0, int_ack = 1'b0, slave_write = 1'b0;
  logic        address_hit = 1'b0, chain_expired = 1'b0;
  logic        end_of_transfer_line_in = 1'b0, channel_check_error_n = 1'b1;
  logic        nmi_on_check_enable = 1'b0;
  logic [7:0]  dma_request = 8'h00, dma_grant, register_data_port_out, first;
  logic [5:0]  slot_master_request = 6'h00, slot_master_grant_n;
  logic [15:0] irq_request = 16'h0000, irq_pending;
  logic [2:0]  far_select_n = 3'h7, slave_register_select_n;
  logic [3:0]  bus_byte_enables_in_n, bus_byte_enables_out_n;
  logic [3:0]  bus_byte_enables_oe_n;
  logic [1:0]  address_enable_out;
  xbp_eot_type eot_mode = xbp_eot_stop;
  logic refresh_line_out_n, refresh_line_oe_n, end_of_transfer_line_out;
  logic end_of_transfer_line_oe_n, transfer_stop, terminal_count;
  logic cycle_ready_line_in_n, cycle_ready_line_out_n, cycle_ready_line_oe_n;
  logic burst_next_address, register_data_port_oe_n, slave_select_out_n;
  logic nmi_request;
  int   n_mismatch = 0, samples_checked = 0;
  // three data-side inputs tied: pull-up refresh, fixed drive values
  xbp_top xbp_top_i (.clk, .nrst, .dma_request, .dma_grant,
    .slot_master_request, .slot_master_grant_n, .refresh_request,
    .isa16_master_active, .refresh_line_in_n(1'b1), .refresh_line_out_n,
    .refresh_line_oe_n, .command_strobe_n, .io_read, .int_ack, .slave_write,
    .address_hit, .eot_mode, .chain_expired, .end_of_transfer_line_in,
    .end_of_transfer_line_out, .end_of_transfer_line_oe_n, .transfer_stop,
    .terminal_count, .irq_request, .irq_pending, .bus_byte_enables_in_n,
    .master_byte_enables_n(4'hA), .bus_byte_enables_out_n,
    .bus_byte_enables_oe_n, .slave_register_select_n, .cycle_ready_line_in_n,
    .cycle_ready_line_out_n, .cycle_ready_line_oe_n, .burst_next_address,
    .read_data(8'h5A), .register_data_port_out, .register_data_port_oe_n,
    .slave_select_out_n, .address_enable_out, .channel_check_error_n,
    .nmi_on_check_enable, .nmi_request);
  xbp_far_end_model xbp_far_end_model_i (.clk, .dma_grant, .far_select_n,
    .bus_byte_enables_out_n, .bus_byte_enables_oe_n, .bus_byte_enables_in_n,
    .cycle_ready_line_in_n);
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs move only at falling edges, results read there too
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset;
    chk({dma_grant, 2'b00, slot_master_grant_n}, 16'h003F);
    chk({bus_byte_enables_oe_n, 2'b00, address_enable_out}, 16'hE0);
    chk({refresh_line_oe_n, end_of_transfer_line_oe_n}, 16'h3);
  endtask
  // each channel alone; the cascade hole must stay ungranted
  task automatic t_dma;
    for (int c = 0; c < 8; c++) begin
      dma_request[c] = 1'b1;
      step(4);
      chk({8'h00, dma_grant}, {8'h00, dma_valid_mask & (8'h01 << c)});
      chk({bus_byte_enables_oe_n, bus_byte_enables_out_n},
          dma_valid_mask[c] ? 16'h0A : 16'hEA);
      for (int k = 0; k < 8 && burst_next_address !== 1'b1; k++) step(1);
      chk(burst_next_address, dma_valid_mask[c]);
      dma_request[c] = 1'b0;
      step(6);
      chk({8'h00, dma_grant}, 16'h0000);
    end
  endtask
  task automatic t_slot;
    for (int s = 0; s < 6; s++) begin
      slot_master_request[s] = 1'b1;
      step(4);
      chk({10'h000, slot_master_grant_n}, {10'h000, ~(6'h01 << s)});
      chk(address_enable_out, 16'h1);
      slot_master_request[s] = 1'b0;
      step(6);
    end
  endtask
  // refresh over dma over slot, refused under a 16-bit adapter
  task automatic t_prio;
    refresh_request = 1'b1;
    dma_request = 8'h01;
    slot_master_request = 6'h01;
    step(4);
    chk({refresh_line_oe_n, refresh_line_out_n, dma_grant}, 16'h0);
    refresh_request = 1'b0;
    step(10);
    chk({8'h00, dma_grant}, 16'h0001);
    dma_request = 8'h00;
    step(10);
    chk({10'h000, slot_master_grant_n}, 16'h003E);
    isa16_master_active = 1'b1;
    refresh_request = 1'b1;
    step(6);
    chk({refresh_line_oe_n, address_enable_out}, {13'h0, 3'b111});
    slot_master_request = 6'h00;
    step(6);
    chk({refresh_line_oe_n, address_enable_out}, {13'h0, 3'b100});
    refresh_request = 1'b0;
    isa16_master_active = 1'b0;
    step(6);
  endtask
  // the channel served first wins the next tie
  task automatic t_rotate;
    dma_request = 8'h03;
    step(4);
    first = dma_grant;
    dma_request = 8'h03 & ~first;
    step(10);
    chk({8'h00, dma_grant}, {8'h00, 8'h03 ^ first});
    dma_request = 8'h00;
    step(6);
    dma_request = 8'h03;
    step(4);
    chk({8'h00, dma_grant}, {8'h00, first});
    dma_request = 8'h00;
    step(6);
  endtask
  task automatic t_slave;
    {address_hit, io_read, slave_write, far_select_n} = 6'b111010;
    command_strobe_n = 1'b0;
    step(3);
    chk({slave_select_out_n, register_data_port_oe_n}, 16'h0);
    chk({cycle_ready_line_oe_n, slave_register_select_n}, 16'h2);
    chk({cycle_ready_line_out_n, register_data_port_out}, 16'h5A);
    command_strobe_n = 1'b1;
    slave_write = 1'b0;
    step(3);
    chk(register_data_port_oe_n, 16'h1);
    {io_read, int_ack, command_strobe_n} = 3'b010;
    step(3);
    chk(register_data_port_oe_n, 16'h0);
    {address_hit, int_ack, command_strobe_n} = 3'b001;
    step(3);
    chk({slave_select_out_n, register_data_port_oe_n}, 16'h3);
  endtask
  task automatic t_eot;
    dma_request = 8'h20;
    step(4);
    end_of_transfer_line_in = 1'b1;
    step(3);
    chk(transfer_stop, 16'h1);
    step(4);
    chk({8'h00, dma_grant}, 16'h0);
    eot_mode = xbp_eot_tc;
    step(4);
    chk({7'h00, terminal_count, dma_grant}, 16'h0120);
    dma_request = 8'h00;
    {end_of_transfer_line_in, chain_expired} = 2'b01;
    eot_mode = xbp_eot_chain;
    step(3);
    chk({end_of_transfer_line_oe_n, end_of_transfer_line_out}, 16'h1);
    eot_mode = xbp_eot_stop;
    step(6);
  endtask
  task automatic t_irq;
    {irq_request, channel_check_error_n, nmi_on_check_enable} = 18'h3FFFD;
    step(3);
    chk(irq_pending, 16'hFFFA);
    chk(nmi_request, 16'h1);
    nmi_on_check_enable = 1'b0;
    step(3);
    chk(nmi_request, 16'h0);
    irq_request = 16'h0000;
  endtask
  initial begin
    step(4);
    nrst = 1'b1;
    t_reset();
    $display("reset test done");
    t_dma();
    $display("dma test done");
    t_slot();
    $display("slot test done");
    t_prio();
    $display("priority test done");
    t_rotate();
    $display("rotation test done");
    t_slave();
    $display("slave test done");
    t_eot();
    $display("end of transfer test done");
    t_irq();
    $display("interrupt test done");
    summarize();
  end
  // about 300 cycles expected; cut a hang well beyond that
  initial begin
    #80000;
    n_mismatch++;
    summarize();
  end
endmodule
bind xbp_top xbp_monitor xbp_monitor_i (.clk, .nrst, .dma_request,
  .dma_grant, .slot_master_grant_n, .refresh_line_oe_n, .refresh_line_out_n,
  .bus_byte_enables_oe_n, .address_hit, .slave_write, .slave_select_out_n,
  .cycle_ready_line_oe_n, .eot_mode, .end_of_transfer_line_oe_n,
  .irq_pending);
`default_nettype wire
